/* core/ssd_pkg.sv */
// Constants, field layout and types for the state-word decoder of the sequencing engine.
// Assumes a 50 MHz core clock; the word's low bits (output drive, primary monitors) are used elsewhere.
//
// Operation
// RL1 - Even bit 20..28 sets aux fault polarity
// RL2 - Odd bit 21..29 unmasks that aux channel
// RL3 - Bit 30 unmasks warning; fault when warning high
// RL4 - Bits 31..34 timeout code; zero disables timeout
// RL5 - Codes 1..15 map 0.1 to 400 ms
// RL6 - Bits 35..38 select the advance condition
// RL7 - Bit 39 inverts the advance condition sense
// RL8 - Bits 40..43 advance delay code
// RL9 - Send-ping select pings delay-field address
// RL10 - Wait-ping select answers pong to delay address
// RL11 - Monitor fault jumps to bits 44..49
// RL12 - Timeout jumps to bits 50..55
// RL13 - Advance event jumps to bits 56..61
// RL14 - Round robin: bit 62 OR global enable
// RL15 - Bit 63 broadcasts on local advance exit
// RL16 - Delay code used directly as link address
// RL17 - Select codes: never, supplies, warning, jump, ping
// RL18 - Software keeps sense zero with never select
// RL19 - Timers restart on every state entry
// RL20 - Priority: monitor, then timeout, then advance
package ssd_pkg;

  localparam int STATE_W       = 6;
  localparam int CODE_W        = 4;
  localparam int AUX_CHANNELS  = 5;
  localparam int PRIMARY_INPUTS = 5;
  localparam int TICK_COUNT_W  = 12;

  // Field positions inside the 64-bit state word
  localparam int POS_AUX_POL   = 20;
  localparam int POS_WARN      = 30;
  localparam int POS_TIMEOUT   = 31;
  localparam int POS_SELECT    = 35;
  localparam int POS_SENSE     = 39;
  localparam int POS_DELAY     = 40;
  localparam int POS_MON_TGT   = 44;
  localparam int POS_TO_TGT    = 50;
  localparam int POS_ADV_TGT   = 56;
  localparam int POS_RR        = 62;
  localparam int POS_BCAST     = 63;

  // Advance condition select codes
  localparam logic [3:0] SEL_NEVER       = 4'h0;
  localparam logic [3:0] SEL_PRIMARY_1   = 4'h1;
  localparam logic [3:0] SEL_AUX_1       = 4'h6;
  localparam logic [3:0] SEL_AUX_LAST    = 4'ha;
  localparam logic [3:0] SEL_WARNING     = 4'hb;
  localparam logic [3:0] SEL_SW_JUMP     = 4'hc;
  localparam logic [3:0] SEL_RESERVED    = 4'hd;
  localparam logic [3:0] SEL_SEND_PING   = 4'he;
  localparam logic [3:0] SEL_WAIT_PING   = 4'hf;

  localparam logic [5:0] RESET_STATE     = 6'h00;

  // Timing: every delay is a whole number of 0.1 ms ticks
  localparam int CLK_PERIOD_NS   = 20;
  localparam int TICK_PERIOD_NS  = 100000;
  localparam int TICK_CYCLES     = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PH_FETCH = 2'b00,
    PH_RUN   = 2'b01
  } ssd_phase_t;

  typedef enum logic [1:0] {
    EXIT_NONE    = 2'b00,
    EXIT_MONITOR = 2'b01,
    EXIT_TIMEOUT = 2'b11,
    EXIT_ADVANCE = 2'b10
  } ssd_exit_t;

  typedef struct packed {
    logic                    broadcast;
    logic                    roundRobin;
    logic [STATE_W-1:0]      advanceTarget;
    logic [STATE_W-1:0]      timeoutTarget;
    logic [STATE_W-1:0]      monitorFaultTarget;
    logic [CODE_W-1:0]       advanceDelayCode;
    logic                    advanceConditionPolarity;
    logic [CODE_W-1:0]       advanceConditionSelect;
    logic [CODE_W-1:0]       timeoutCode;
    logic                    warnUnmask;
    logic [AUX_CHANNELS-1:0] auxUnmask;
    logic [AUX_CHANNELS-1:0] auxPolarity;
  } ssd_word_t;

  // Delay code to tick count; code 0 gives zero ticks
  function automatic logic [TICK_COUNT_W-1:0] ssd_ticks(input logic [CODE_W-1:0] code);
    logic [TICK_COUNT_W-1:0] t;
    t = 12'h000;
    case (code)
      4'h1: t = 12'h001;
      4'h2: t = 12'h002;
      4'h3: t = 12'h004;
      4'h4: t = 12'h007;
      4'h5: t = 12'h00a;
      4'h6: t = 12'h014;
      4'h7: t = 12'h028;
      4'h8: t = 12'h046;
      4'h9: t = 12'h064;
      4'ha: t = 12'h0c8;
      4'hb: t = 12'h190;
      4'hc: t = 12'h2bc;
      4'hd: t = 12'h3e8;
      4'he: t = 12'h7d0;
      4'hf: t = 12'hfa0;
      default: t = 12'h000;
    endcase
    return t;
  endfunction : ssd_ticks

endpackage : ssd_pkg

/* core/ssd_delay_timer.sv */
// Tick-based delay timer: counts whole 0.1 ms ticks from its own prescaler.
// Assumes restart is held while the owner is not timing; code 0 means expired at once.
`timescale 1ns/1ps
module ssd_delay_timer #(
  parameter int TICK_CYCLES = ssd_pkg::TICK_CYCLES
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  input  wire logic                        clkEn,
  input  wire logic                        restart,
  input  wire logic                        run,
  input  wire logic [ssd_pkg::CODE_W-1:0]  code,
  output logic                             expired
);
  localparam int PRE_W = $clog2(TICK_CYCLES);

  logic [PRE_W-1:0]                     preCnt_q;
  logic [ssd_pkg::TICK_COUNT_W-1:0]     tickCnt_q;
  logic [ssd_pkg::TICK_COUNT_W-1:0]     target;

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  assign target  = ssd_pkg::ssd_ticks(code);                                // RL5
  assign expired = (tickCnt_q >= target);

  // Prescaler restarts with the count, so the first tick is a full one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt_q  <= '0;
      tickCnt_q <= '0;
    end else if (clkEn) begin
      if (restart) begin                                                    // RL19
        preCnt_q  <= '0;
        tickCnt_q <= '0;
      end else if (run && !expired) begin
        if (preCnt_q == PRE_W'(TICK_CYCLES - 1)) begin
          preCnt_q  <= '0;
          tickCnt_q <= tickCnt_q + 12'h001;
        end else begin
          preCnt_q <= preCnt_q + PRE_W'(1);
        end
      end
    end
  end

endmodule : ssd_delay_timer

/* core/ssd_state_decode.sv */
// State-word decoder and exit logic for one sequencing engine.
// Assumes an external fetch unit answers fetchReq_q with the 64-bit word of stateNum_q and wordValid.
`timescale 1ns/1ps
module ssd_state_decode #(
  parameter int TICK_CYCLES = ssd_pkg::TICK_CYCLES
) (
  input  wire logic                                 core_clk,
  input  wire logic                                 rst_n,
  input  wire logic                                 clkEn,
  input  wire logic [63:0]                          stateWord,
  input  wire logic                                 wordValid,
  input  wire logic [ssd_pkg::PRIMARY_INPUTS-1:0]   primarySupplyIn,
  input  wire logic [ssd_pkg::AUX_CHANNELS-1:0]     auxSupplyIn,
  input  wire logic                                 warningIn,
  input  wire logic                                 swJump,
  input  wire logic                                 globalRoundRobinEn,
  input  wire logic                                 pingRx,
  output logic [ssd_pkg::STATE_W-1:0]               stateNum_q,
  output logic                                      fetchReq_q,
  output logic                                      roundRobinEn_q,
  output logic                                      pingTx_q,
  output logic                                      pongTx_q,
  output logic                                      broadcastTx_q,
  output logic [ssd_pkg::CODE_W-1:0]                linkAddr_q,
  output ssd_pkg::ssd_exit_t                        exitCause_q
);

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  ssd_pkg::ssd_phase_t                 phase_q;
  ssd_pkg::ssd_word_t                  cfg_q;
  ssd_pkg::ssd_word_t                  cfgNew;
  logic                                firstRun_q;
  logic                                pingDone_q;
  logic                                swJumpPend_q;
  logic                                pingHeard_q;
  logic                                running;
  logic                                enterRun;
  logic [ssd_pkg::AUX_CHANNELS-1:0]    auxFault;
  logic                                monFault;
  logic                                toExpired;
  logic                                toFault;
  logic                                seqExpired;
  logic                                rawCond;
  logic                                condMet;
  logic                                linkSel;
  logic                                seqEvent;
  logic                                exitNow;
  logic [ssd_pkg::STATE_W-1:0]         nextState;
  ssd_pkg::ssd_exit_t                  cause;

  assign running  = (phase_q == ssd_pkg::PH_RUN);
  assign enterRun = (phase_q == ssd_pkg::PH_FETCH) && wordValid;

  // Field extraction from the fetched word
  genvar gi;
  for (gi = 0; gi < ssd_pkg::AUX_CHANNELS; gi++) begin : g_aux
    assign cfgNew.auxPolarity[gi] = stateWord[ssd_pkg::POS_AUX_POL + 2*gi];     // RL1
    assign cfgNew.auxUnmask[gi]   = stateWord[ssd_pkg::POS_AUX_POL + 2*gi + 1]; // RL2
    // Fault when the level equals the programmed polarity, only if unmasked
    assign auxFault[gi] = cfg_q.auxUnmask[gi] && (auxSupplyIn[gi] == cfg_q.auxPolarity[gi]); // RL1 RL2
  end
  assign cfgNew.warnUnmask               = stateWord[ssd_pkg::POS_WARN];                   // RL3
  assign cfgNew.timeoutCode              = stateWord[ssd_pkg::POS_TIMEOUT +: 4];           // RL4
  assign cfgNew.advanceConditionSelect   = stateWord[ssd_pkg::POS_SELECT +: 4];            // RL6
  assign cfgNew.advanceConditionPolarity = stateWord[ssd_pkg::POS_SENSE];                  // RL7
  assign cfgNew.advanceDelayCode         = stateWord[ssd_pkg::POS_DELAY +: 4];             // RL8
  assign cfgNew.monitorFaultTarget       = stateWord[ssd_pkg::POS_MON_TGT +: 6];           // RL11
  assign cfgNew.timeoutTarget            = stateWord[ssd_pkg::POS_TO_TGT +: 6];            // RL12
  assign cfgNew.advanceTarget            = stateWord[ssd_pkg::POS_ADV_TGT +: 6];           // RL13
  assign cfgNew.roundRobin               = stateWord[ssd_pkg::POS_RR];                     // RL14
  assign cfgNew.broadcast                = stateWord[ssd_pkg::POS_BCAST];                  // RL15

  assign monFault = running && ((|auxFault) || (cfg_q.warnUnmask && warningIn));           // RL3

  ssd_delay_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timeout (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .restart  (!running),
    .run      (1'b1),
    .code     (cfg_q.timeoutCode),
    .expired  (toExpired)
  );

  // Code zero reads as expired inside the timer, so it must be gated off here
  assign toFault = running && (cfg_q.timeoutCode != 4'h0) && toExpired;                    // RL4 RL12

  always_comb begin
    rawCond = 1'b0;
    if (cfg_q.advanceConditionSelect == ssd_pkg::SEL_NEVER) begin                          // RL17
      rawCond = 1'b0;
    end else if (cfg_q.advanceConditionSelect < ssd_pkg::SEL_AUX_1) begin
      rawCond = primarySupplyIn[3'(cfg_q.advanceConditionSelect - ssd_pkg::SEL_PRIMARY_1)];
    end else if (cfg_q.advanceConditionSelect <= ssd_pkg::SEL_AUX_LAST) begin
      rawCond = auxSupplyIn[3'(cfg_q.advanceConditionSelect - ssd_pkg::SEL_AUX_1)];
    end else if (cfg_q.advanceConditionSelect == ssd_pkg::SEL_WARNING) begin
      rawCond = warningIn;
    end else if (cfg_q.advanceConditionSelect == ssd_pkg::SEL_SW_JUMP) begin
      rawCond = swJumpPend_q;
    end else if (cfg_q.advanceConditionSelect == ssd_pkg::SEL_SEND_PING) begin
      rawCond = pingDone_q;                                                                // RL9
    end else if (cfg_q.advanceConditionSelect == ssd_pkg::SEL_WAIT_PING) begin
      rawCond = pingHeard_q;                                                               // RL10
    end else begin
      rawCond = 1'b0;
    end
  end

  // Sense bit inverts every source; with select 0 software must leave it clear
  assign condMet = running && (rawCond ^ cfg_q.advanceConditionPolarity);                  // RL7 RL18
  assign linkSel = (cfg_q.advanceConditionSelect >= ssd_pkg::SEL_SEND_PING);

  // Condition must stay true for the whole delay; a drop restarts the wait
  ssd_delay_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_advance (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .restart  (!condMet),
    .run      (!linkSel),
    .code     (cfg_q.advanceDelayCode),
    .expired  (seqExpired)
  );

  // On link selects the delay field is an address, not a wait
  assign seqEvent = condMet && (linkSel || seqExpired);                                    // RL8 RL9 RL16
  assign exitNow  = monFault || toFault || seqEvent;

  always_comb begin
    nextState = stateNum_q;
    cause     = ssd_pkg::EXIT_NONE;
    if (monFault) begin                                                                    // RL20
      nextState = cfg_q.monitorFaultTarget;                                                // RL11
      cause     = ssd_pkg::EXIT_MONITOR;
    end else if (toFault) begin
      nextState = cfg_q.timeoutTarget;                                                     // RL12
      cause     = ssd_pkg::EXIT_TIMEOUT;
    end else if (seqEvent) begin
      nextState = cfg_q.advanceTarget;                                                     // RL13
      cause     = ssd_pkg::EXIT_ADVANCE;
    end
  end

  // Phase and current state number
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q     <= ssd_pkg::PH_FETCH;
      stateNum_q  <= ssd_pkg::RESET_STATE;
      exitCause_q <= ssd_pkg::EXIT_NONE;
    end else if (clkEn) begin
      case (phase_q)
        ssd_pkg::PH_FETCH: begin
          if (wordValid) begin
            phase_q <= ssd_pkg::PH_RUN;
          end
        end
        ssd_pkg::PH_RUN: begin
          if (exitNow) begin
            phase_q     <= ssd_pkg::PH_FETCH;
            stateNum_q  <= nextState;
            exitCause_q <= cause;
          end
        end
        default: phase_q <= ssd_pkg::PH_FETCH;
      endcase
    end
  end

  // Word capture and the fetch request level
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q      <= '0;
      fetchReq_q <= 1'b0;
      firstRun_q <= 1'b0;
    end else if (clkEn) begin
      if (enterRun) begin
        cfg_q <= cfgNew;
      end
      fetchReq_q <= (phase_q == ssd_pkg::PH_FETCH) ? !wordValid : exitNow;
      firstRun_q <= enterRun;
    end
  end

  // Latched events; a new event in the clearing cycle survives
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      swJumpPend_q <= 1'b0;
      pingHeard_q  <= 1'b0;
      pingDone_q   <= 1'b0;
    end else if (clkEn) begin
      swJumpPend_q <= swJump || (swJumpPend_q && !(running && exitNow));
      pingHeard_q  <= (pingRx && cfg_q.advanceConditionSelect == ssd_pkg::SEL_WAIT_PING && running)
                      || (pingHeard_q && !(running && exitNow));
      pingDone_q   <= pingTx_q || (pingDone_q && !(running && exitNow));
    end
  end

  // Interchip link messages; the delay code is the message address as-is
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pingTx_q      <= 1'b0;
      pongTx_q      <= 1'b0;
      broadcastTx_q <= 1'b0;
      linkAddr_q    <= 4'h0;
    end else if (clkEn) begin
      pingTx_q      <= running && firstRun_q && !exitNow
                       && (cfg_q.advanceConditionSelect == ssd_pkg::SEL_SEND_PING);       // RL9
      pongTx_q      <= running && seqEvent && !monFault && !toFault
                       && (cfg_q.advanceConditionSelect == ssd_pkg::SEL_WAIT_PING);       // RL10
      broadcastTx_q <= running && seqEvent && !monFault && !toFault && cfg_q.broadcast;    // RL15
      if (running) begin
        linkAddr_q <= cfg_q.advanceDelayCode;                                              // RL16
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      roundRobinEn_q <= 1'b0;
    end else if (clkEn) begin
      roundRobinEn_q <= cfg_q.roundRobin || globalRoundRobinEn;                            // RL14
    end
  end

  // Checks
  sequence s_enter;
    clkEn && phase_q == ssd_pkg::PH_FETCH && wordValid;
  endsequence

  sequence s_ping_state;
    clkEn && running && firstRun_q && !exitNow && cfg_q.advanceConditionSelect == ssd_pkg::SEL_SEND_PING;
  endsequence

  a_monitor_jump: assert property (@(posedge core_clk) disable iff (!rst_n) // RL11
    clkEn && monFault |=> stateNum_q == $past(cfg_q.monitorFaultTarget) && exitCause_q == ssd_pkg::EXIT_MONITOR)
    else $error("monitor fault did not jump to its target");

  a_timeout_jump: assert property (@(posedge core_clk) disable iff (!rst_n) // RL12
    clkEn && toFault && !monFault |=> stateNum_q == $past(cfg_q.timeoutTarget)
      && exitCause_q == ssd_pkg::EXIT_TIMEOUT)
    else $error("timeout did not jump to its target");

  a_advance_jump: assert property (@(posedge core_clk) disable iff (!rst_n) // RL13
    clkEn && seqEvent && !monFault && !toFault |=> stateNum_q == $past(cfg_q.advanceTarget)
      && exitCause_q == ssd_pkg::EXIT_ADVANCE)
    else $error("advance event did not jump to its target");

  a_timeout_off: assert property (@(posedge core_clk) disable iff (!rst_n) // RL4
    running && cfg_q.timeoutCode == 4'h0 |-> !toFault)
    else $error("timeout fired with code zero");

  a_mask_quiet: assert property (@(posedge core_clk) disable iff (!rst_n) // RL2
    running && cfg_q.auxUnmask == 5'h00 && !cfg_q.warnUnmask |-> !monFault)
    else $error("masked channels raised a monitor fault");

  a_ping_sent: assert property (@(posedge core_clk) disable iff (!rst_n) // RL9
    s_ping_state |=> pingTx_q && linkAddr_q == $past(cfg_q.advanceDelayCode))
    else $error("ping not sent to delay-field address");

  a_entry_restart: assert property (@(posedge core_clk) disable iff (!rst_n) // RL19
    s_enter ##1 clkEn && running |-> !toFault)
    else $error("timeout fired on the first cycle of a state");

  a_broadcast_cause: assert property (@(posedge core_clk) disable iff (!rst_n) // RL15
    broadcastTx_q |-> exitCause_q == ssd_pkg::EXIT_ADVANCE && $past(cfg_q.broadcast))
    else $error("broadcast without a local advance exit");

  a_rr_or: assert property (@(posedge core_clk) disable iff (!rst_n) // RL14
    clkEn && globalRoundRobinEn |=> roundRobinEn_q)
    else $error("global round robin enable ignored");

  a_prio_order: assert property (@(posedge core_clk) disable iff (!rst_n) // RL20
    clkEn && monFault && toFault |=> exitCause_q == ssd_pkg::EXIT_MONITOR)
    else $error("timeout took priority over monitor fault");

endmodule : ssd_state_decode

/* verif/ssd_fetch_model.sv */
// Fetch-side partner: answers each state-word fetch after a chosen lag.
// Assumes state 0 holds the word under test and every other state a blank word.
`timescale 1ns/1ps
module ssd_fetch_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        fetchReq_q,
  input  wire logic [5:0]  stateNum_q,
  input  wire logic [63:0] word0,
  input  wire logic [3:0]  lag,
  output logic [63:0]      stateWord,
  output logic             wordValid
);
  logic [3:0]  cnt_q;
  logic        done_q;
  logic [63:0] last_q;
  // Outside the valid cycle the bus shows the inverse, so stale data never looks right
  assign stateWord = wordValid ? last_q : ~last_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wordValid <= 1'b0;
      cnt_q     <= 4'h0;
      done_q    <= 1'b0;
      last_q    <= 64'h0;
    end else if (wordValid) begin
      wordValid <= 1'b0;
      done_q    <= 1'b1;
    end else if (!fetchReq_q) begin
      done_q <= 1'b0;
      cnt_q  <= 4'h0;
    end else if (!done_q && cnt_q == lag) begin
      wordValid <= 1'b1;
      last_q    <= (stateNum_q == 6'h00) ? word0 : 64'h0;
    end else if (!done_q) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : ssd_fetch_model

/* verif/test_ssd_state_decode.sv */
// Self-checking bench for the state-word decoder.
// Assumes targets 1, 2, 3 hold blank words so the engine parks there after an exit.
`timescale 1ns/1ps
module test_ssd_state_decode;
  localparam int T = 4;
  logic core_clk, rstN, wordValid, warnIn, swJump, glbRr, pingRx;
  logic sawPing, sawPong, sawBc, rrEn, pingTx, pongTx, bcTx, fetchReq;
  logic [63:0] stateWord, word0;
  logic [4:0]  primIn, auxIn;
  logic [3:0]  lag, linkAddr, pAddr;
  logic [5:0]  stateNum;
  ssd_pkg::ssd_exit_t cause;
  int mismatches, checksDone, ticks, cyc;

  ssd_state_decode #(.TICK_CYCLES(T)) DUT (.core_clk(core_clk), .rst_n(rstN), .clkEn(1'b1),
    .stateWord(stateWord), .wordValid(wordValid), .primarySupplyIn(primIn), .auxSupplyIn(auxIn),
    .warningIn(warnIn), .swJump(swJump), .globalRoundRobinEn(glbRr), .pingRx(pingRx),
    .stateNum_q(stateNum), .fetchReq_q(fetchReq), .roundRobinEn_q(rrEn), .pingTx_q(pingTx),
    .pongTx_q(pongTx), .broadcastTx_q(bcTx), .linkAddr_q(linkAddr), .exitCause_q(cause));
  ssd_fetch_model PART (.core_clk(core_clk), .rst_n(rstN), .fetchReq_q(fetchReq), .stateNum_q(stateNum),
    .word0(word0), .lag(lag), .stateWord(stateWord), .wordValid(wordValid));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Link pulses last one cycle, so they are caught here rather than polled
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      {sawPing, sawPong, sawBc} <= 3'b000;
    end else begin
      if (pingTx === 1'b1) sawPing <= 1'b1;
      if (pongTx === 1'b1) sawPong <= 1'b1;
      if (bcTx === 1'b1) sawBc <= 1'b1;
      if ((pingTx | pongTx) === 1'b1) pAddr <= linkAddr;
    end
  end
  always @(posedge core_clk) begin
    ticks <= ticks + 1;
    if (ticks > 30000) begin
      mismatches = mismatches + 1;
      end_sim();
    end
  end

  task automatic end_sim;
    if (mismatches == 0 && checksDone > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checksDone = checksDone + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Builds the upper word; monitor, timeout and advance targets are 1, 2 and 3
  function automatic logic [63:0] wd(input logic [4:0] pol, input logic [4:0] unm, input logic [3:0] to,
    input logic [3:0] sel, input logic sns, input logic [3:0] dly, input logic [2:0] fl);
    logic [63:0] w;
    w = 64'h0;
    for (int i = 0; i < 5; i++) begin
      w[20+2*i] = pol[i];
      w[21+2*i] = unm[i];
    end
    w[30] = fl[0];
    w[34:31] = to;
    w[38:35] = sel;
    w[39] = sns;
    w[43:40] = dly;
    w[63:44] = {fl[2:1], 6'h03, 6'h02, 6'h01};
    return w;
  endfunction : wd
  task automatic run(input logic [63:0] w, input logic [4:0] p, input logic [4:0] a, input logic wn);
    @(posedge core_clk);
    rstN <= 1'b0;
    word0 <= w;
    primIn <= p;
    auxIn <= a;
    warnIn <= wn;
    repeat (2) @(posedge core_clk);
    rstN <= 1'b1;
  endtask : run
  task automatic ex(input int lim, input logic [5:0] st, input logic [1:0] cs);
    cyc = 0;
    do begin
      @(negedge core_clk);
      cyc++;
    end while (stateNum === 6'h00 && cyc < lim);
    chk("stateNum", 64'(stateNum), 64'(st));
    chk("exitCause", 64'(cause), 64'(cs));
  endtask : ex

  task automatic t_monitor;
    for (int c = 0; c < 5; c++) for (int p = 0; p < 2; p++) for (int l = 0; l < 3; l++) begin
      run(wd(5'(p) << c, (l == 2) ? 5'h00 : 5'h01 << c, 4'h0, 4'h0, 1'b0, 4'h0, 3'h0), 5'h00,
          (l[0] ^ (l == 2 && p == 1)) ? 5'h1f : 5'h00, 1'b0);
      ex(12, (l == p) ? 6'h01 : 6'h00, (l == p) ? 2'b01 : 2'b00);
    end
    for (int b = 0; b < 2; b++) begin
      run(wd(5'h00, 5'h00, 4'h0, 4'h0, 1'b0, 4'h0, 3'(b)), 5'h00, 5'h00, 1'b1);
      ex(12, 6'(b), 2'(b));
    end
  endtask : t_monitor
  task automatic t_timeout;
    int tk[6] = '{0, 1, 2, 4, 7, 10};
    for (int k = 0; k < 6; k++) begin
      run(wd(5'h00, 5'h00, 4'(k), 4'h0, 1'b0, 4'h0, 3'h0), 5'h00, 5'h00, 1'b0);
      ex(60, (k == 0) ? 6'h00 : 6'h02, (k == 0) ? 2'b00 : 2'b11);
      if (k > 0) chk("toTime", 64'(cyc >= tk[k] * T + 2 && cyc <= tk[k] * T + 8), 64'h1);
    end
  endtask : t_timeout
  task automatic t_advance;
    logic [10:0] src;
    for (int s = 0; s < 14; s++) for (int n = 0; n < 2; n++) for (int m = 0; m < 2; m++) begin
      src = (m == 1) ? 11'(n == 0 ? 11'h7ff : 11'h0) : 11'(n == 0 ? 11'h0 : 11'h7ff);
      if (s != 12 && !(n == 1 && (s == 0 || s == 13))) begin
        run(wd(5'h00, 5'h00, 4'h0, 4'(s), 1'(n), 4'h0, 3'h0), src[4:0], src[9:5], src[10]);
        ex(12, (m == 1 && s > 0 && s < 12) ? 6'h03 : 6'h00, (m == 1 && s > 0 && s < 12) ? 2'b10 : 2'b00);
      end
    end
    run(wd(5'h00, 5'h00, 4'h0, 4'hc, 1'b0, 4'h0, 3'h0), 5'h00, 5'h00, 1'b0);
    ex(12, 6'h00, 2'b00);
    @(posedge core_clk);
    swJump <= 1'b1;
    @(posedge core_clk);
    swJump <= 1'b0;
    ex(12, 6'h03, 2'b10);
    run(wd(5'h00, 5'h00, 4'h0, 4'h1, 1'b0, 4'h3, 3'h0), 5'h01, 5'h00, 1'b0);
    ex(40, 6'h03, 2'b10);
    chk("advTime", 64'(cyc >= 4 * T + 2 && cyc <= 4 * T + 8), 64'h1);
  endtask : t_advance
  task automatic t_link;
    run(wd(5'h00, 5'h00, 4'h0, 4'he, 1'b0, 4'h9, 3'h4), 5'h00, 5'h00, 1'b0);
    ex(12, 6'h03, 2'b10);
    // Exit pulses rise with the state change and are latched one edge later
    @(negedge core_clk);
    chk("pingAddr", {sawPing, sawBc, 58'h0, pAddr}, {2'b11, 58'h0, 4'h9});
    run(wd(5'h00, 5'h00, 4'h0, 4'hf, 1'b0, 4'h5, 3'h0), 5'h00, 5'h00, 1'b0);
    ex(12, 6'h00, 2'b00);
    @(posedge core_clk);
    pingRx <= 1'b1;
    @(posedge core_clk);
    pingRx <= 1'b0;
    ex(8, 6'h03, 2'b10);
    @(negedge core_clk);
    chk("pongAddr", {sawPong, sawBc, 58'h0, pAddr}, {2'b10, 58'h0, 4'h5});
  endtask : t_link
  task automatic t_priority;
    run(wd(5'h01, 5'h01, 4'h1, 4'h1, 1'b0, 4'h0, 3'h4), 5'h01, 5'h01, 1'b0);
    ex(12, 6'h01, 2'b01);
    @(negedge core_clk);
    chk("bcast", 64'(sawBc), 64'h0);
    lag <= 4'h5;
    run(wd(5'h00, 5'h00, 4'h1, 4'h1, 1'b0, 4'h3, 3'h0), 5'h01, 5'h00, 1'b0);
    ex(40, 6'h02, 2'b11);
    lag <= 4'h0;
  endtask : t_priority
  task automatic t_rr;
    for (int k = 0; k < 3; k++) begin
      glbRr <= (k == 1);
      run(wd(5'h00, 5'h00, 4'h0, 4'h0, 1'b0, 4'h0, {1'b0, k == 0, 1'b0}), 5'h00, 5'h00, 1'b0);
      ex(10, 6'h00, 2'b00);
      chk("roundRobin", 64'(rrEn), 64'(k < 2));
    end
  endtask : t_rr

  initial begin
    {rstN, warnIn, swJump, glbRr, pingRx} = 5'b0;
    {primIn, auxIn, lag, word0} = '0;
    mismatches = 0;
    checksDone = 0;
    ticks = 0;
    repeat (20) @(posedge core_clk);
    t_monitor();
    t_timeout();
    t_advance();
    t_link();
    t_priority();
    t_rr();
    end_sim();
  end
endmodule : test_ssd_state_decode
